//--- core/itt_timer.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "itt_defines.svh"

// How it works
// - Clock output: system or subclock, /32 to /4
// - Codes 0xxx: interval timer from system prescaler
// - Codes 11xx hold subclock prescaler and counter
// - Count readable, resets zero, ignores writes
// - Mode layout; bit 4 reads one
module itt_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic subclk_in,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic clk_out,
  output logic overflow
);

  logic rst_meta_b;
  logic rst_sync_b;
  itt_pkg::itt_state_type st_reg;
  itt_pkg::itt_state_type st_next;
  itt_pkg::itt_src_type src;
  logic [3:0] sys_exp;
  logic [3:0] sub_exp;
  logic [`ITT_SYS_PRE_W-1:0] sys_mask;
  logic [`ITT_SUB_PRE_W-1:0] sub_mask;
  logic sub_edge;
  logic sys_tick;
  logic sub_tick;
  logic tick;
  logic cko_sel;

  itt_pre_if #(.W(`ITT_SYS_PRE_W)) sys_if ();
  itt_pre_if #(.W(`ITT_SUB_PRE_W)) sub_if ();

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // System prescaler runs on every system clock
  assign sys_if.inc = 1'b1;
  assign sys_if.clr = 1'b0;

  // Subclock prescaler advances on each synchronised subclock rising edge outside the hold codes
  assign sub_edge = st_reg.sub_sync & ~st_reg.sub_prev;
  assign sub_if.inc = sub_edge;
  assign sub_if.clr = (src == itt_pkg::ITT_SRC_HOLD);

  itt_prescaler #(.W(`ITT_SYS_PRE_W)) u_system_prescaler (
    .clk(clk),
    .rst_b(rst_sync_b),
    .pre(sys_if.pre)
  );

  itt_prescaler #(.W(`ITT_SUB_PRE_W)) u_subclock_prescaler (
    .clk(clk),
    .rst_b(rst_sync_b),
    .pre(sub_if.pre)
  );

  // Counter source from the top bits of the prescaler selection
  always_comb begin
    if (!st_reg.psel[3]) begin
      src = itt_pkg::ITT_SRC_SYS;
    end else if (!st_reg.psel[2]) begin
      src = itt_pkg::ITT_SRC_SUB;
    end else begin
      src = itt_pkg::ITT_SRC_HOLD;
    end
  end

  // Tap widths: divide by 2 to this power
  always_comb begin
    unique case (st_reg.psel[2:0])
      3'h0: sys_exp = `ITT_TAP_SYS_8192;
      3'h1: sys_exp = `ITT_TAP_SYS_4096;
      3'h2: sys_exp = `ITT_TAP_SYS_2048;
      3'h3: sys_exp = `ITT_TAP_SYS_512;
      3'h4: sys_exp = `ITT_TAP_SYS_256;
      3'h5: sys_exp = `ITT_TAP_SYS_128;
      3'h6: sys_exp = `ITT_TAP_SYS_32;
      3'h7: sys_exp = `ITT_TAP_SYS_8;
    endcase
    // 256 counts at 32.768 kHz: 1 s, 0.5 s, 0.25 s, 0.03125 s
    unique case (st_reg.psel[1:0])
      2'h0: sub_exp = `ITT_TAP_SUB_128;
      2'h1: sub_exp = `ITT_TAP_SUB_64;
      2'h2: sub_exp = `ITT_TAP_SUB_32;
      2'h3: sub_exp = `ITT_TAP_SUB_4;
    endcase
  end

  // A tap pulses when all its low prescaler bits are about to roll over
  assign sys_mask = `ITT_SYS_PRE_W'((14'h0001 << sys_exp) - 14'h0001);
  assign sub_mask = `ITT_SUB_PRE_W'((8'h01 << sub_exp) - 8'h01);
  assign sys_tick = &(sys_if.cnt | ~sys_mask);
  assign sub_tick = sub_edge & (&(sub_if.cnt | ~sub_mask));
  assign tick = (src == itt_pkg::ITT_SRC_SYS) ? sys_tick :
                (src == itt_pkg::ITT_SRC_SUB) ? sub_tick : 1'b0;

  // Clock output picks a prescaler bit, so it is a square wave
  always_comb begin
    unique case (st_reg.cks[1:0])
      2'h0: cko_sel = st_reg.cks[2] ? sub_if.cnt[`ITT_CKO_DIV32_BIT] :
                                      sys_if.cnt[`ITT_CKO_DIV32_BIT];
      2'h1: cko_sel = st_reg.cks[2] ? sub_if.cnt[`ITT_CKO_DIV16_BIT] :
                                      sys_if.cnt[`ITT_CKO_DIV16_BIT];
      2'h2: cko_sel = st_reg.cks[2] ? sub_if.cnt[`ITT_CKO_DIV8_BIT] :
                                      sys_if.cnt[`ITT_CKO_DIV8_BIT];
      2'h3: cko_sel = st_reg.cks[2] ? sub_if.cnt[`ITT_CKO_DIV4_BIT] :
                                      sys_if.cnt[`ITT_CKO_DIV4_BIT];
    endcase
  end

  // Next state: synchroniser, mode register, counter, read port
  always_comb begin
    st_next = st_reg;
    st_next.sub_meta = subclk_in;
    st_next.sub_sync = st_reg.sub_meta;
    st_next.sub_prev = st_reg.sub_sync;
    st_next.clk_out = cko_sel;
    st_next.ovf = 1'b0;
    // Count writes are dropped; only the mode register takes data
    if (wr && addr == `ITT_MODE_ADDR) begin
      st_next.cks = wdata[`ITT_CKS_MSB:`ITT_CKS_LSB];
      st_next.psel = wdata[`ITT_PSEL_MSB:`ITT_PSEL_LSB];
    end
    if (src == itt_pkg::ITT_SRC_HOLD) begin
      st_next.count = `ITT_COUNT_RESET;
    end else if (tick) begin
      st_next.count = st_reg.count + 8'h01;
      st_next.ovf = (st_reg.count == 8'hFF);
    end
    // Read data stand only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (rd) begin
      if (addr == `ITT_MODE_ADDR) begin
        st_next.rdata = {st_reg.cks, 1'b1, st_reg.psel};
      end else if (addr == `ITT_COUNT_ADDR) begin
        st_next.rdata = st_reg.count;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_reg <= '{sub_meta: 1'b0, sub_sync: 1'b0, sub_prev: 1'b0,
                  cks: `ITT_CKS_RESET, psel: `ITT_PSEL_RESET,
                  count: `ITT_COUNT_RESET, clk_out: 1'b0, ovf: 1'b0,
                  rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign clk_out = st_reg.clk_out;
  assign overflow = st_reg.ovf;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  logic mode_wr;
  assign mode_wr = wr && addr == `ITT_MODE_ADDR;

  cko_sys32_a: assert property (
    (st_reg.cks == 3'h0 && !mode_wr) |=> (clk_out == $past(sys_if.cnt[4]))
  ) else $error("clock output not system /32 tap");

  cko_sub4_a: assert property (
    (st_reg.cks == 3'h7) |=> (clk_out == $past(sub_if.cnt[1]))
  ) else $error("clock output not subclock /4 tap");

  intv_tick_a: assert property (
    (st_reg.psel == 4'h0 && sys_if.cnt == 13'h1FFF)
      |=> (st_reg.count == $past(st_reg.count) + 8'h01)
  ) else $error("interval tick at /8192 missed");

  intv_idle_a: assert property (
    (st_reg.psel == 4'h7 && sys_if.cnt[2:0] != 3'h7)
      |=> $stable(st_reg.count)
  ) else $error("counter moved between /8 ticks");

  tbase_tick_a: assert property (
    (st_reg.psel == 4'hB && sub_edge && sub_if.cnt[1:0] == 2'h3)
      |=> (st_reg.count == $past(st_reg.count) + 8'h01)
  ) else $error("time base tick missed");

  hold_reset_a: assert property (
    (st_reg.psel[3:2] == 2'b11) |=> (st_reg.count == 8'h00 && sub_if.cnt == '0)
  ) else $error("held counter or prescaler not zero");

  count_ro_a: assert property (
    (wr && addr == `ITT_COUNT_ADDR && !tick && src != itt_pkg::ITT_SRC_HOLD)
      |=> $stable(st_reg.count)
  ) else $error("count changed by a write");

  count_read_a: assert property (
    (rd && addr == `ITT_COUNT_ADDR) |=> (rdata == $past(st_reg.count))
  ) else $error("count read mismatch");

  mode_rsvd_a: assert property (
    (rd && addr == `ITT_MODE_ADDR) |=> (rdata[4] && rdata[7:5] == $past(st_reg.cks))
  ) else $error("mode read layout wrong");

  wrap_ovf_a: assert property (
    overflow |-> (st_reg.count == 8'h00 && $past(st_reg.count) == 8'hFF)
  ) else $error("overflow without wrap");

  ovf_intv_c: cover property (overflow && !st_reg.psel[3]);
  ovf_tbase_c: cover property (overflow && st_reg.psel[3:2] == 2'b10);
  hold_c: cover property (st_reg.psel[3:2] == 2'b11 ##1 st_reg.psel[3] == 1'b0);

endmodule

`default_nettype wire

//--- core/itt_defines.svh
`ifndef ITT_DEFINES_SVH
`define ITT_DEFINES_SVH

// Register offsets on the plain register port
`define ITT_MODE_ADDR 8'hB0
`define ITT_COUNT_ADDR 8'hB1

// Mode register layout and reset values
`define ITT_CKS_MSB 7
`define ITT_CKS_LSB 5
`define ITT_RSVD_BIT 4
`define ITT_PSEL_MSB 3
`define ITT_PSEL_LSB 0
`define ITT_CKS_RESET 3'h0
`define ITT_PSEL_RESET 4'h0
`define ITT_COUNT_RESET 8'h00

// Prescaler widths: system prescaler reaches /8192, subclock prescaler /128
`define ITT_SYS_PRE_W 13
`define ITT_SUB_PRE_W 7

// Clock output taps, as prescaler bit index (divide by 2 to the index plus one)
`define ITT_CKO_DIV32_BIT 4
`define ITT_CKO_DIV16_BIT 3
`define ITT_CKO_DIV8_BIT 2
`define ITT_CKO_DIV4_BIT 1

// Tick taps, as count of low prescaler bits that must all be one
`define ITT_TAP_SYS_8192 4'hD
`define ITT_TAP_SYS_4096 4'hC
`define ITT_TAP_SYS_2048 4'hB
`define ITT_TAP_SYS_512 4'h9
`define ITT_TAP_SYS_256 4'h8
`define ITT_TAP_SYS_128 4'h7
`define ITT_TAP_SYS_32 4'h5
`define ITT_TAP_SYS_8 4'h3
`define ITT_TAP_SUB_128 4'h7
`define ITT_TAP_SUB_64 4'h6
`define ITT_TAP_SUB_32 4'h5
`define ITT_TAP_SUB_4 4'h2

`endif

//--- core/itt_pkg.sv
package itt_pkg;

  // Where the counter takes its tick from
  typedef enum logic [1:0] {
    ITT_SRC_SYS = 2'b00,
    ITT_SRC_SUB = 2'b01,
    ITT_SRC_HOLD = 2'b11
  } itt_src_type;

  // State of the timer top apart from the reset synchroniser flops
  typedef struct packed {
    logic sub_meta;
    logic sub_sync;
    logic sub_prev;
    logic [2:0] cks;
    logic [3:0] psel;
    logic [7:0] count;
    logic clk_out;
    logic ovf;
    logic [7:0] rdata;
  } itt_state_type;

endpackage

//--- core/itt_pre_if.sv
`timescale 1ns/1ps
`default_nettype none

interface itt_pre_if #(parameter int W = 8);
  logic inc;
  logic clr;
  logic [W-1:0] cnt;

  modport ctl (output inc, output clr, input cnt);
  modport pre (input inc, input clr, output cnt);
endinterface

`default_nettype wire

//--- core/itt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

// Binary prescaler with increment and clear inputs; every bit is a divided clock
module itt_prescaler #(parameter int W = 8) (
  input wire logic clk,
  input wire logic rst_b,
  itt_pre_if.pre pre
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } itt_pre_state_type;

  itt_pre_state_type st_reg;
  itt_pre_state_type st_next;

  // Clear wins over increment so a held prescaler stays at zero
  always_comb begin
    st_next = st_reg;
    if (pre.clr) begin
      st_next.cnt = '0;
    end else if (pre.inc) begin
      st_next.cnt = st_reg.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pre.cnt = st_reg.cnt;

endmodule

`default_nettype wire

//--- tb/itt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "itt_defines.svh"

module itt_timer_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic subclk_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic clk_out;
  logic overflow;
  int n_errors = 0;
  int checks_done = 0;
  int sub_cnt = 0;
  // Tick period per prescaler code, in system clocks (subclock is 10 clocks)
  int tick_per [12] = '{8192, 4096, 2048, 512, 256, 128, 32, 8, 1280, 640, 320, 40};
  // Clock output period per select code, in system clocks
  int cko_per [8] = '{32, 16, 8, 4, 320, 160, 80, 40};

  itt_timer dut (
    .clk(clk),
    .rst_b(rst_b),
    .subclk_in(subclk_in),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .clk_out(clk_out),
    .overflow(overflow)
  );

  // 20 MHz system clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Subclock far faster than a crystal, so the time base fits a short run
  always @(posedge clk) begin
    if (sub_cnt == 4) begin
      sub_cnt <= 0;
      subclk_in <= ~subclk_in;
    end else begin
      sub_cnt <= sub_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd_reg(a, d);
    check(what, {8'h00, exp}, {8'h00, d});
  endtask

  // Rising edges of the clock output over n cycles
  task automatic count_edges(input int n, output int e);
    logic prev;
    #1;
    e = 0;
    prev = clk_out;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (clk_out === 1'b1 && prev === 1'b0) e++;
      prev = clk_out;
    end
  endtask

  // Bounded wait for the overflow pulse; returns cycles waited
  task automatic wait_ovf(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (overflow !== 1'b1 && n < lim);
    // A wait that runs out is a fault of its own
    if (overflow !== 1'b1) begin
      n_errors++;
      $display("ERROR overflow expected 1 seen timeout");
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Run is about 66k cycles; this limit only cuts a hang
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    logic [7:0] v0;
    logic [7:0] v1;
    int e;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // Register map, reset values and access kinds
    rd_chk(`ITT_MODE_ADDR, 8'h10, "mode reset");
    rd_chk(`ITT_COUNT_ADDR, 8'h00, "count reset");
    wr_reg(`ITT_COUNT_ADDR, 8'h55);
    rd_chk(`ITT_COUNT_ADDR, 8'h00, "count write");
    rd_chk(8'h42, 8'h00, "unmapped read");
    wr_reg(`ITT_MODE_ADDR, 8'h6A);
    rd_chk(`ITT_MODE_ADDR, 8'h7A, "mode fields");
    $display("test registers done");
    // Tick rate of every running code, over two tick periods
    for (int c = 0; c < 12; c++) begin
      wr_reg(`ITT_MODE_ADDR, 8'(c));
      rd_reg(`ITT_COUNT_ADDR, v0);
      repeat (2 * tick_per[c] - 2) @(posedge clk);
      rd_reg(`ITT_COUNT_ADDR, v1);
      check("count step", 16'h0002, {8'h00, 8'(v1 - v0)});
    end
    $display("test tick rates done");
    // Hold codes clear a running counter and freeze the subclock prescaler
    for (int c = 12; c < 16; c++) begin
      wr_reg(`ITT_MODE_ADDR, 8'h87);
      repeat (40) @(posedge clk);
      wr_reg(`ITT_MODE_ADDR, 8'h80 | 8'(c));
      rd_chk(`ITT_COUNT_ADDR, 8'h00, "count hold");
      count_edges(400, e);
      check("held subclock edges", 16'h0000, 16'(e));
      // An unknown output would show no edges either, so look at its level
      check("held clock output", 16'h0000, {15'h0000, clk_out});
    end
    $display("test hold done");
    // Clock output rate for every select code
    for (int c = 0; c < 8; c++) begin
      wr_reg(`ITT_MODE_ADDR, {3'(c), 5'h00});
      repeat (16) @(posedge clk);
      count_edges(640, e);
      check("clk_out edges", 16'(640 / cko_per[c]), 16'(e));
    end
    $display("test clock output done");
    // Wrap to zero with overflow, then a full 256 ticks to the next
    wr_reg(`ITT_MODE_ADDR, 8'h07);
    wait_ovf(3000, e);
    rd_chk(`ITT_COUNT_ADDR, 8'h00, "count after wrap");
    wait_ovf(3000, e);
    check("overflow spacing", 16'h07FE, 16'(e));
    // Time base wraps once per 256 ticks of the /4 subclock tap
    wr_reg(`ITT_MODE_ADDR, 8'h0B);
    wait_ovf(11000, e);
    wait_ovf(11000, e);
    check("time base spacing", 16'h2800, 16'(e));
    $display("test overflow done");
    end_of_test();
  end
endmodule

`default_nettype wire
